//--- logic/uir_uart.sv
// Serial port core: AHB-Lite registers, transmitter and receiver with
// infrared timing, ninth-bit addressing and a maskable interrupt.
// Assumes single-word AHB-Lite transfers and a serial input synchronous to the clock.
`timescale 1ns/1ps

module uir_uart #(
  parameter int unsigned OSC_DIV = uir_pkg::OSC_DIV
) (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // AHB-Lite slave.
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Serial line.
  input wire logic i_rxd,
  output logic o_txd,
  // Interrupt.
  output logic o_irq
);

  typedef enum logic [1:0] {
    UIR_IDLE = 2'b00,
    UIR_START = 2'b01,
    UIR_BITS = 2'b10,
    UIR_STOP = 2'b11
  } uir_state_e;

  // ---------------------------------------------------------------
  // Register port.
  // ---------------------------------------------------------------
  logic [7:0] cfg_r;
  logic [3:0] imask_r;
  logic [3:0] istat_r;
  logic [7:0] addr_r;
  logic wr_pend_r;
  logic rd_pend_r;
  logic tick;
  logic [3:0] ev;

  wire take = i_hsel && i_htrans[1] && i_hready;
  wire wr_cfg = wr_pend_r && (addr_r == uir_pkg::ADDR_CFG);
  wire wr_txd = wr_pend_r && (addr_r == uir_pkg::ADDR_TXD);
  wire wr_istat = wr_pend_r && (addr_r == uir_pkg::ADDR_ISTAT);
  wire wr_imask = wr_pend_r && (addr_r == uir_pkg::ADDR_IMASK);
  wire rd_rxd = rd_pend_r && (addr_r == uir_pkg::ADDR_RXD);
  wire ir_mode = cfg_r[uir_pkg::CFG_IR];
  wire len7 = cfg_r[uir_pkg::CFG_LEN7];
  wire par_en = cfg_r[uir_pkg::CFG_PAR];
  wire stop2 = cfg_r[uir_pkg::CFG_STOP2];

  // Address phase is latched; reads take one wait state so read data leaves a flop.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      addr_r <= 8'h00;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      if (take) begin
        addr_r <= i_haddr[7:0];
      end
      wr_pend_r <= take && i_hwrite;
      rd_pend_r <= take && !i_hwrite;
      o_hreadyout <= !(take && !i_hwrite);
      o_hresp <= 1'b0;
    end
  end

  // Writable configuration and interrupt state; a new event wins over its clear.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cfg_r <= uir_pkg::CFG_RST;
      imask_r <= uir_pkg::IMASK_RST;
      istat_r <= 4'h0;
      o_irq <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg_r <= i_hwdata[uir_pkg::CFG_W-1:0];
      end
      if (wr_imask) begin
        imask_r <= i_hwdata[uir_pkg::IRQ_W-1:0];
      end
      istat_r <= (istat_r & ~(wr_istat ? i_hwdata[3:0] : 4'h0)) | ev;
      o_irq <= |(istat_r & imask_r);
    end
  end

  uir_baud #(
    .OSC_DIV(OSC_DIV)
  ) u_baud (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_code(cfg_r[3:0]),
    .o_tick16(tick)
  );

  // ---------------------------------------------------------------
  // Transmitter.
  // ---------------------------------------------------------------
  uir_state_e tx_st_r;
  logic [8:0] txbuf_r;
  logic txfull_r;
  logic [8:0] txsh_r;
  logic [3:0] tx_ph_r;
  logic [3:0] tx_cnt_r;
  logic tx_bit;

  // Bits after the start bit: data, then the ninth bit when parity position is on.
  wire [3:0] nbits = (len7 ? 4'h7 : 4'h8) + {3'h0, par_en};
  wire tx_load = tick && (tx_st_r == UIR_IDLE) && txfull_r;
  wire tx_ph_end = tick && (tx_ph_r == uir_pkg::TICK_LAST);
  // Seven-bit words put the ninth bit straight after data bit six.
  wire [8:0] tx_frame = len7 ? {1'b1, txbuf_r[8], txbuf_r[6:0]} : txbuf_r;
  // Normal mode holds the level; infrared mode pulses low for 3/16 on zeros.
  wire tx_line = ir_mode ? !(!tx_bit && (tx_ph_r < uir_pkg::IR_PULSE_TICKS)) : tx_bit;

  always_comb begin
    unique case (tx_st_r)
      UIR_IDLE: tx_bit = 1'b1;
      UIR_START: tx_bit = 1'b0;
      UIR_BITS: tx_bit = txsh_r[0];
      UIR_STOP: tx_bit = 1'b1;
    endcase
  end

  // Buffer accepts a write only while empty; a write to a full buffer is dropped.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      txbuf_r <= 9'h000;
      txfull_r <= 1'b0;
    end else if (tx_load) begin
      txfull_r <= 1'b0;
    end else if (wr_txd && !txfull_r) begin
      txbuf_r <= i_hwdata[uir_pkg::WORD_W-1:0];
      txfull_r <= 1'b1;
    end
  end

  // Transmit sequencer stepping sixteen ticks per bit.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tx_st_r <= UIR_IDLE;
      txsh_r <= 9'h000;
      tx_ph_r <= 4'h0;
      tx_cnt_r <= 4'h0;
      o_txd <= 1'b1;
    end else begin
      o_txd <= tx_line;
      if (tx_load) begin
        tx_st_r <= UIR_START;
        txsh_r <= tx_frame;
        tx_ph_r <= 4'h0;
      end else if (tick && (tx_st_r != UIR_IDLE)) begin
        tx_ph_r <= tx_ph_r + 4'h1;
      end
      if (tx_ph_end) begin
        unique case (tx_st_r)
          UIR_IDLE: tx_st_r <= UIR_IDLE;
          UIR_START: begin
            tx_st_r <= UIR_BITS;
            tx_cnt_r <= nbits - 4'h1;
          end
          UIR_BITS: begin
            txsh_r <= {1'b1, txsh_r[8:1]};
            tx_cnt_r <= tx_cnt_r - 4'h1;
            if (tx_cnt_r == 4'h0) begin
              tx_st_r <= UIR_STOP;
              tx_cnt_r <= {3'h0, stop2};
            end
          end
          UIR_STOP: begin
            tx_cnt_r <= tx_cnt_r - 4'h1;
            if (tx_cnt_r == 4'h0) begin
              tx_st_r <= UIR_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Receiver.
  // ---------------------------------------------------------------
  uir_state_e rx_st_r;
  logic rxd_r;
  logic [3:0] rx_ph_r;
  logic [3:0] rx_cnt_r;
  logic [8:0] rxsh_r;
  logic [1:0] votes_r;
  logic [3:0] run_r;
  logic ir_zero_r;
  logic [8:0] rxreg_r;
  logic rxfull_r;
  logic fe_r;

  // Line level meaning data zero: high in infrared timing, low otherwise.
  wire z = ir_mode ? rxd_r : !rxd_r;
  // A run must reach two ticks to count, so single-tick glitches vanish.
  wire ir_hit = tick && z && (run_r == uir_pkg::IR_MIN_RUN - 4'h1);
  wire vote_win = (rx_ph_r >= uir_pkg::VOTE_FIRST) && (rx_ph_r <= uir_pkg::VOTE_LAST);
  wire [1:0] votes_n = votes_r + {1'b0, tick && z && vote_win};
  wire bit_zero = ir_mode ? ir_zero_r : votes_n[1];
  wire rx_ph_end = tick && (rx_ph_r == uir_pkg::TICK_LAST);
  wire rx_go = (rx_st_r == UIR_IDLE) && (ir_mode ? ir_hit : (tick && z));
  wire rx_done = rx_ph_end && (rx_st_r == UIR_STOP);
  // Seven-bit words shift in one bit fewer, so realign before storing.
  wire [8:0] rx_word = len7 ? {rxsh_r[8], 1'b0, rxsh_r[7:1]} : rxsh_r;
  // Without the ninth bit, seven-bit words sit one place higher than eight-bit ones.
  wire [8:0] rx_word9 = par_en ? rx_word : {1'b0, len7 ? {1'b0, rxsh_r[8:2]} : rxsh_r[8:1]};

  // Input register and infrared pulse-run tracking.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rxd_r <= 1'b1;
      run_r <= 4'h0;
    end else begin
      rxd_r <= i_rxd;
      if (tick) begin
        run_r <= (z && (run_r != uir_pkg::TICK_LAST)) ? run_r + 4'h1 : (z ? run_r : 4'h0);
      end
    end
  end

  // Receive sequencer; infrared frames align on the pulse, which starts each bit.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rx_st_r <= UIR_IDLE;
      rx_ph_r <= 4'h0;
      rx_cnt_r <= 4'h0;
      rxsh_r <= 9'h000;
      votes_r <= 2'h0;
      ir_zero_r <= 1'b0;
    end else if (rx_go) begin
      rx_st_r <= UIR_START;
      rx_ph_r <= ir_mode ? uir_pkg::IR_MIN_RUN : 4'h1;
      votes_r <= 2'h0;
      ir_zero_r <= ir_mode;
    end else if (tick && (rx_st_r != UIR_IDLE)) begin
      rx_ph_r <= rx_ph_r + 4'h1;
      votes_r <= rx_ph_end ? 2'h0 : votes_n;
      ir_zero_r <= !rx_ph_end && (ir_zero_r || ir_hit);
      if (rx_ph_end) begin
        unique case (rx_st_r)
          UIR_IDLE: rx_st_r <= UIR_IDLE;
          UIR_START: begin
            rx_st_r <= bit_zero ? UIR_BITS : UIR_IDLE;
            rx_cnt_r <= nbits - 4'h1;
          end
          UIR_BITS: begin
            rxsh_r <= {!bit_zero, rxsh_r[8:1]};
            rx_cnt_r <= rx_cnt_r - 4'h1;
            if (rx_cnt_r == 4'h0) begin
              rx_st_r <= UIR_STOP;
            end
          end
          UIR_STOP: rx_st_r <= UIR_IDLE;
        endcase
      end
    end
  end

  // Receive register and framing flag; the ninth-bit event is decoded from rx_word9 as it is stored.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rxreg_r <= 9'h000;
      rxfull_r <= 1'b0;
      fe_r <= 1'b0;
    end else begin
      if (rx_done) begin
        rxreg_r <= rx_word9;
        fe_r <= bit_zero;
      end
      rxfull_r <= rx_done || (rxfull_r && !rd_rxd);
    end
  end

  // Events into the sticky status.
  assign ev[uir_pkg::EV_RX] = rx_done;
  assign ev[uir_pkg::EV_NINTH] = rx_done && rx_word9[uir_pkg::NINTH_POS];
  assign ev[uir_pkg::EV_FRAMING] = rx_done && bit_zero;
  assign ev[uir_pkg::EV_TXEMPTY] = tx_load;

  // ---------------------------------------------------------------
  // Read data.
  // ---------------------------------------------------------------
  wire [3:0] stat = {tx_st_r != UIR_IDLE, fe_r, !txfull_r, rxfull_r};
  logic [31:0] rd_mux;

  always_comb begin
    unique case (addr_r)
      uir_pkg::ADDR_CFG: rd_mux = {24'h000000, cfg_r};
      uir_pkg::ADDR_STAT: rd_mux = {28'h0000000, stat};
      uir_pkg::ADDR_TXD: rd_mux = {23'h0, txbuf_r};
      uir_pkg::ADDR_RXD: rd_mux = {23'h0, rxreg_r};
      uir_pkg::ADDR_ISTAT: rd_mux = {28'h0000000, istat_r};
      uir_pkg::ADDR_IMASK: rd_mux = {28'h0000000, imask_r};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Read data is captured in the wait state and held until the next read.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_hrdata <= 32'h00000000;
    end else if (rd_pend_r) begin
      o_hrdata <= rd_mux;
    end
  end

endmodule

//--- common/uir_pkg.sv
// Shared constants of the serial port with infrared timing and ninth-bit mode.
// Assumes a 100 MHz system clock and a 32-bit AHB-Lite register port.
package uir_pkg;

  // ---------------------------------------------------------------
  // Clock and bit timing.
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned OSC_HZ = 1_843_200;
  // System clocks per oscillator period, rounded down.
  localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;
  localparam logic [3:0] TICK_LAST = 4'hf;     // Sixteen ticks per baud period.
  localparam logic [3:0] IR_PULSE_TICKS = 4'h3; // Infrared pulse, 3/16 of a bit.
  localparam logic [3:0] IR_MIN_RUN = 4'h2;     // Runs of one tick are noise.
  localparam logic [3:0] VOTE_FIRST = 4'h7;     // Normal mode votes at 7, 8 and 9.
  localparam logic [3:0] VOTE_LAST = 4'h9;

  // ---------------------------------------------------------------
  // Register byte addresses.
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_TXD = 8'h08;
  localparam logic [7:0] ADDR_RXD = 8'h0c;
  localparam logic [7:0] ADDR_ISTAT = 8'h10;
  localparam logic [7:0] ADDR_IMASK = 8'h14;

  // Configuration fields.
  localparam int unsigned CFG_W = 8;
  localparam int unsigned CFG_LEN7 = 4;
  localparam int unsigned CFG_PAR = 5;
  localparam int unsigned CFG_STOP2 = 6;
  localparam int unsigned CFG_IR = 7;
  localparam logic [7:0] CFG_RST = 8'h00;

  // Status fields.
  localparam int unsigned ST_RXFULL = 0;
  localparam int unsigned ST_TXEMPTY = 1;
  localparam int unsigned ST_FRAMING = 2;
  localparam int unsigned ST_TXBUSY = 3;

  // Interrupt status and mask fields.
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned EV_RX = 0;
  localparam int unsigned EV_NINTH = 1;
  localparam int unsigned EV_FRAMING = 2;
  localparam int unsigned EV_TXEMPTY = 3;
  localparam logic [3:0] IMASK_RST = 4'h0;

  // Data word: eight data bits and the ninth (parity-position) bit.
  localparam int unsigned WORD_W = 9;
  localparam int unsigned NINTH_POS = 8;

endpackage

//--- logic/uir_baud.sv
// Baud tick generator: one pulse per sixteenth of a baud period.
// Assumes the code on i_code is stable while a character is in flight.
`timescale 1ns/1ps
module uir_baud #(
  parameter int unsigned OSC_DIV = uir_pkg::OSC_DIV
) (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Rate selection.
  input wire logic [3:0] i_code,
  // Tick output.
  output logic o_tick16
);

  // Ratio is a power of two, or three times a power of two when the top bit is set.
  function automatic logic [8:0] ratio_of(input logic [3:0] code);
    logic [8:0] base;
    base = code[3] ? 9'h003 : 9'h001;
    ratio_of = base << code[2:0];
  endfunction

  logic [15:0] presc_r;
  logic [8:0] ratio_cnt_r;
  logic osc_en;
  logic [8:0] ratio_last;

  // Oscillator enable comes from the system clock, so baud rates are only as exact as OSC_DIV.
  assign osc_en = (presc_r == 16'(OSC_DIV - 1));
  assign ratio_last = ratio_of(i_code) - 9'h001;

  // Prescaler from system clock down to the oscillator rate.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      presc_r <= 16'h0000;
    end else begin
      presc_r <= osc_en ? 16'h0000 : presc_r + 16'h0001;
    end
  end

  // Ratio counter: baud equals oscillator over sixteen times the ratio.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ratio_cnt_r <= 9'h000;
      o_tick16 <= 1'b0;
    end else begin
      o_tick16 <= osc_en && (ratio_cnt_r >= ratio_last);
      if (osc_en) begin
        ratio_cnt_r <= (ratio_cnt_r >= ratio_last) ? 9'h000 : ratio_cnt_r + 9'h001;
      end
    end
  end

endmodule

//--- bench/uir_uart_props.sv
// Checker of bus timing, line pulse widths and interrupt gating at the top ports.
// Assumes the fast rate (OSC_DIV 1, baud code 0) for the line timing checks.
`timescale 1ns/1ps
module uir_uart_props #(
  parameter int unsigned OSC_DIV = 1
) (
  // Clock, reset and bus.
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  // Line and interrupt.
  input wire logic o_txd,
  input wire logic o_irq
);
  logic wr_r;
  logic [7:0] adr_r;
  logic [7:0] cfg_r;
  logic [3:0] msk_r;
  // Line checks only hold at one tick per clock, so they are gated.
  wire take = i_hsel & i_htrans[1] & i_hready;
  wire fast = (OSC_DIV == 1) && (cfg_r[3:0] == 4'h0);
  wire ir_on = fast & cfg_r[7];
  wire nm_on = fast & ~cfg_r[7];
  // Shadow the configuration and mask as write data phases complete.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wr_r <= 1'b0;
      adr_r <= 8'h00;
      cfg_r <= 8'h00;
      msk_r <= 4'h0;
    end else if (i_hready) begin
      wr_r <= take & i_hwrite;
      adr_r <= i_haddr[7:0];
      if (wr_r && adr_r == 8'h00) begin
        cfg_r <= i_hwdata[7:0];
      end
      if (wr_r && adr_r == 8'h14) begin
        msk_r <= i_hwdata[3:0];
      end
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // A taken read is followed by one wait state, then the data.
  sequence s_rd;
    take && !i_hwrite;
  endsequence
  sequence s_wait1;
    !o_hreadyout ##1 o_hreadyout;
  endsequence
  a_read_one_wait: assert property (s_rd |=> s_wait1)
    else $error("read did not take one wait state");
  a_write_no_wait: assert property (take && i_hwrite |=> o_hreadyout)
    else $error("write data phase stalled");
  a_resp_okay: assert property (o_hresp == 1'b0)
    else $error("response not okay");
  a_rdata_holds: assert property (o_hreadyout |=> $stable(o_hrdata))
    else $error("read data changed outside a read");
  a_upper_zero: assert property (s_rd |-> ##2 o_hrdata[31:9] == 23'h0)
    else $error("upper read bits not zero");
  a_unmapped_zero: assert property (s_rd ##0 i_haddr[7:0] > 8'h14 |-> ##2 o_hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_ir_pulse_width: assert property ($fell(o_txd) && ir_on |=> !o_txd [*2] ##1 o_txd)
    else $error("infrared pulse not three ticks");
  a_bit_sixteen: assert property ($fell(o_txd) && nm_on |-> !o_txd [*8] ##1 !o_txd [*8])
    else $error("zero bit shorter than sixteen ticks");
  a_irq_masked: assert property ((msk_r == 4'h0) [*2] |-> !o_irq)
    else $error("interrupt high with all sources masked");
endmodule
bind uir_uart uir_uart_props #(.OSC_DIV(OSC_DIV)) uir_uart_props_i (.i_clk_sys, .i_rst,
  .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout,
  .o_hresp, .o_txd, .o_irq);

//--- bench/uir_peer.sv
// Remote serial node: sends frames on the receive line and decodes the transmit line.
// Assumes one baud tick per system clock, so a bit is sixteen clocks.
`timescale 1ns/1ps
module uir_peer (
  // Clock.
  input wire logic i_clk_sys,
  // Line.
  input wire logic i_txd,
  output logic o_rxd
);
  initial o_rxd = 1'b1;
  // Park the line at idle: high in normal timing, dark (low) in infrared.
  task automatic idle(input logic ir);
    @(posedge i_clk_sys);
    o_rxd <= ~ir;
  endtask
  // One frame and one idle bit; gl flips tick 8 of that bit to test voting.
  task automatic send(input logic [8:0] w, input logic nine, input logic ir,
                      input logic bad_stop, input logic [3:0] gl);
    logic b;
    logic v;
    for (int i = 0; i < 11 + nine; i++) begin
      b = (i == 0) ? 1'b0 : (i < 9) ? w[i-1] : (nine && i == 9) ? w[8] :
          (i == 9 + nine) ? ~bad_stop : 1'b1;
      for (int c = 0; c < 16; c++) begin
        @(posedge i_clk_sys);
        v = ir ? (~b & (c < 3)) : b;
        if (i == gl && c == 8) begin
          v = ~v;
        end
        o_rxd <= v;
      end
    end
  endtask
  // A single-tick infrared pulse, too short to count as a zero.
  task automatic glitch();
    @(posedge i_clk_sys);
    o_rxd <= 1'b1;
    @(posedge i_clk_sys);
    o_rxd <= 1'b0;
  endtask
  // Decode one frame; infrared zero is low at tick 1, normal bits are read at tick 8.
  task automatic recv(output logic [8:0] w, output logic ok, input logic nine, input logic ir);
    int n;
    w = 9'h000;
    for (n = 0; n < 4000 && i_txd !== 1'b0; n++) begin
      @(posedge i_clk_sys);
      #1;
    end
    repeat (ir ? 1 : 8) @(posedge i_clk_sys);
    for (int k = 0; k < 8 + nine; k++) begin
      repeat (16) @(posedge i_clk_sys);
      #1;
      w[k] = i_txd;
    end
    repeat (16) @(posedge i_clk_sys);
    #1;
    ok = (n < 4000) && (i_txd === 1'b1);
    repeat (16) @(posedge i_clk_sys);
  endtask
endmodule

//--- bench/irda_sir_and_ninth_bit_address_rx_tb_top.sv
// Bench: registers, receive and transmit in both timings, framing and interrupt gating.
// Assumes OSC_DIV 1 and baud code 0, so a bit is sixteen clocks.
`timescale 1ns/1ps
module irda_sir_and_ninth_bit_address_rx_tb_top;
  typedef struct packed {
    logic ir;
    logic nine;
    logic [8:0] w;
    logic [3:0] gl;
    logic [8:0] rx_exp;
    logic irq_exp;
  } uir_row_s;
  localparam logic [7:0] A_CFG = uir_pkg::ADDR_CFG;
  localparam logic [7:0] A_ST = uir_pkg::ADDR_STAT;
  localparam logic [7:0] A_RX = uir_pkg::ADDR_RXD;
  localparam logic [7:0] A_IS = uir_pkg::ADDR_ISTAT;
  localparam logic [7:0] A_IM = uir_pkg::ADDR_IMASK;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic rxd;
  logic txd;
  logic irq;
  logic [31:0] rd;
  logic [8:0] tw;
  logic ok;
  int err_total = 0;
  int check_count = 0;
  // Row 0 carries a one-tick glitch that the three-sample vote must outvote.
  uir_row_s rows [7] = '{
    '{1'b0, 1'b0, 9'h0a5, 4'h3, 9'h0a5, 1'b0},
    '{1'b0, 1'b1, 9'h1c3, 4'hf, 9'h1c3, 1'b1},
    '{1'b0, 1'b1, 9'h03c, 4'hf, 9'h03c, 1'b0},
    '{1'b0, 1'b0, 9'h1ff, 4'hf, 9'h0ff, 1'b0},
    '{1'b1, 1'b0, 9'h05a, 4'hf, 9'h05a, 1'b0},
    '{1'b1, 1'b1, 9'h181, 4'hf, 9'h181, 1'b1},
    '{1'b1, 1'b0, 9'h000, 4'hf, 9'h000, 1'b0}};
  always #5 clk = ~clk;
  uir_uart #(.OSC_DIV(1)) uir_uart_i (.i_clk_sys(clk), .i_rst(rst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(), .i_rxd(rxd),
    .o_txd(txd), .o_irq(irq));
  uir_peer uir_peer_i (.i_clk_sys(clk), .i_txd(txd), .o_rxd(rxd));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask
  // A used-up wait counts as a mismatch and ends the run.
  task automatic give_up();
    chk(32'h0, 32'h1);
    finish_test();
  endtask
  // One single transfer; read data lands in rd at the edge that ends the data phase.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 80);
    rd = hrdata;
    if (n >= 80) begin
      give_up();
    end
  endtask
  // Poll the sticky word-received event, so unread words are still seen.
  task automatic wait_rx();
    for (int k = 0; k < 60; k++) begin
      ahb(1'b0, A_IS, 32'h0);
      if (rd[uir_pkg::EV_RX] === 1'b1) begin
        return;
      end
    end
    give_up();
  endtask
  // Idle level first, then the mode; any half frame from the switch is flushed.
  task automatic set_mode(input logic [7:0] cfg);
    uir_peer_i.idle(cfg[uir_pkg::CFG_IR]);
    ahb(1'b1, A_CFG, {24'h0, cfg});
    repeat (300) @(posedge clk);
    ahb(1'b0, A_RX, 32'h0);
    ahb(1'b1, A_IS, 32'hf);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    ahb(1'b0, A_CFG, 32'h0);
    chk(rd, {24'h0, uir_pkg::CFG_RST});
    ahb(1'b0, A_ST, 32'h0);
    chk(rd, 32'h1 << uir_pkg::ST_TXEMPTY);
    ahb(1'b1, 8'h20, 32'hffff_ffff);
    ahb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    $display("reset and unmapped test done");
    for (int r = 0; r < 7; r++) begin
      set_mode({rows[r].ir, 1'b0, rows[r].nine, 5'h00});
      ahb(1'b1, A_IM, 32'h2);
      uir_peer_i.send(rows[r].w, rows[r].nine, rows[r].ir, 1'b0, rows[r].gl);
      wait_rx();
      chk({31'h0, irq}, {31'h0, rows[r].irq_exp});
      ahb(1'b0, A_RX, 32'h0);
      chk(rd, {23'h0, rows[r].rx_exp});
      ahb(1'b0, A_IS, 32'h0);
      chk(rd & 32'h7, {30'h0, rows[r].irq_exp, 1'b1});
      ahb(1'b1, A_IS, 32'hf);
      fork
        uir_peer_i.recv(tw, ok, rows[r].nine, rows[r].ir);
        ahb(1'b1, uir_pkg::ADDR_TXD, {23'h0, rows[r].w});
      join
      chk({22'h0, ok, tw}, {23'h1, rows[r].rx_exp});
      $display("row %0d done", r);
    end
    // The wait outlasts a whole frame, so a pulse taken as a start bit would show.
    uir_peer_i.glitch();
    repeat (300) @(posedge clk);
    ahb(1'b0, A_IS, 32'h0);
    chk(rd & 32'h1, 32'h0);
    $display("short pulse test done");
    set_mode(8'h00);
    uir_peer_i.send(9'h055, 1'b0, 1'b0, 1'b1, 4'hf);
    wait_rx();
    ahb(1'b0, A_ST, 32'h0);
    chk(rd & 32'h4, 32'h4);
    ahb(1'b0, A_IS, 32'h0);
    chk(rd & 32'h4, 32'h4);
    ahb(1'b1, A_IS, 32'hf);
    uir_peer_i.send(9'h033, 1'b0, 1'b0, 1'b0, 4'hf);
    wait_rx();
    ahb(1'b0, A_ST, 32'h0);
    chk(rd & 32'h4, 32'h0);
    $display("framing test done");
    // Seven-bit words with two stop bits; the peer's eighth bit lands on the first stop.
    set_mode(8'h50);
    uir_peer_i.send(9'h0d5, 1'b0, 1'b0, 1'b0, 4'hf);
    wait_rx();
    ahb(1'b0, A_RX, 32'h0);
    chk(rd, 32'h055);
    fork
      uir_peer_i.recv(tw, ok, 1'b0, 1'b0);
      ahb(1'b1, uir_pkg::ADDR_TXD, 32'h055);
    join
    chk({22'h0, ok, tw}, 32'h2d5);
    $display("short word test done");
    set_mode(8'h20);
    ahb(1'b1, A_IM, 32'h0);
    uir_peer_i.send(9'h1aa, 1'b1, 1'b0, 1'b0, 4'hf);
    wait_rx();
    chk({31'h0, irq}, 32'h0);
    ahb(1'b0, A_IS, 32'h0);
    chk(rd & 32'h2, 32'h2);
    ahb(1'b0, A_RX, 32'h0);
    chk(rd, 32'h1aa);
    ahb(1'b1, A_IM, 32'h2);
    ahb(1'b0, A_ST, 32'h0);
    chk({31'h0, irq}, 32'h1);
    ahb(1'b1, A_IS, 32'hf);
    ahb(1'b0, A_ST, 32'h0);
    chk({31'h0, irq}, 32'h0);
    uir_peer_i.send(9'h011, 1'b1, 1'b0, 1'b0, 4'hf);
    wait_rx();
    ahb(1'b0, A_IS, 32'h0);
    chk(rd & 32'h2, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("ninth bit test done");
    finish_test();
  end
endmodule
